// [logic/rx_status_pkg.sv]
// shared constants and helpers for the receive-port status bank
package rx_status_pkg;

    localparam int NUM_PORTS = 4;
    localparam int PORT_W    = 2;
    localparam int LIMIT_W   = 8;

    // register offsets
    localparam logic [7:0] ADDR_PORT_SELECT = 8'h4C;
    localparam logic [7:0] ADDR_LINK_FLAGS  = 8'h4E;
    localparam logic [7:0] ADDR_RATE_INT    = 8'h4F;
    localparam logic [7:0] ADDR_RATE_FRAC   = 8'h50;
    localparam logic [7:0] ADDR_ALARM       = 8'h51;
    localparam logic [7:0] ADDR_VOLTAGE     = 8'h52;
    localparam logic [7:0] ADDR_TEMP        = 8'h53;

    // link flag bit positions
    localparam int BIT_LINE_INCONS = 7;
    localparam int BIT_LINE_CHG    = 6;
    localparam int BIT_CODING      = 5;
    localparam int BIT_OVERFLOW    = 4;
    localparam int BIT_CAMERA_ERR  = 3;
    localparam int BIT_SETTLED     = 2;
    localparam int BIT_CLK_MISSING = 1;
    localparam int BIT_LINE_TOTAL  = 0;

    // remote sensor field positions
    localparam int ALARM_W       = 6;
    localparam int LEVEL_W       = 3;
    localparam int SUPPLY1_LSB   = 4;
    localparam int SUPPLY0_LSB   = 0;
    localparam int TEMP_LSB      = 0;

    // port select fields: write enables low, read port above
    localparam int PSEL_WEN_LSB  = 0;
    localparam int PSEL_READ_LSB = 4;

    // reset values
    localparam logic [7:0] RST_BYTE        = 8'h00;
    localparam logic [7:0] RST_PORT_SELECT = 8'h01;
    localparam logic [LIMIT_W-1:0] MIN_FAULT_LIMIT = 8'h01;

    // sticky flag: a set in the clearing cycle wins
    function automatic logic sticky_next(
        input logic set_evt,
        input logic clr_evt,
        input logic cur
    );
        sticky_next = set_evt | (cur & ~clr_evt);
    endfunction : sticky_next

endpackage : rx_status_pkg

// [logic/port_link_flags.sv]
// status flags and rate bytes of one receive port
module port_link_flags (
    input  wire logic                                core_clk,
    input  wire logic                                rst_n,
    input  wire logic                                line_width_inconsistent,
    input  wire logic                                line_width_changed,
    input  wire logic                                link_coding_fault,
    input  wire logic                                fifo_overflow,
    input  wire logic                                camera_rx_error,
    input  wire logic                                rate_measure_settled,
    input  wire logic                                link_clock_missing,
    input  wire logic                                frame_line_total_changed,
    input  wire logic                                fault_count_en,
    input  wire logic [rx_status_pkg::LIMIT_W-1:0]   link_fault_limit,
    input  wire logic [7:0]                          rate_integer_byte,
    input  wire logic [7:0]                          rate_fraction_byte,
    input  wire logic                                flags_read,
    output logic      [7:0]                          flags_reg,
    output logic      [7:0]                          rate_int_reg,
    output logic      [7:0]                          rate_frac_reg
);

    logic coding_seen;

    // a fault at limit 1 drops lock first, so the coding error is lost
    assign coding_seen = link_coding_fault & fault_count_en
                       & (link_fault_limit > rx_status_pkg::MIN_FAULT_LIMIT); // [R4]

    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            flags_reg <= rx_status_pkg::RST_BYTE;
        end else begin
            flags_reg[rx_status_pkg::BIT_LINE_INCONS] <= rx_status_pkg::sticky_next(
                line_width_inconsistent, flags_read,
                flags_reg[rx_status_pkg::BIT_LINE_INCONS]); // [R1]
            flags_reg[rx_status_pkg::BIT_LINE_CHG] <= rx_status_pkg::sticky_next(
                line_width_changed, flags_read,
                flags_reg[rx_status_pkg::BIT_LINE_CHG]); // [R2]
            flags_reg[rx_status_pkg::BIT_CODING] <= rx_status_pkg::sticky_next(
                coding_seen, flags_read,
                flags_reg[rx_status_pkg::BIT_CODING]); // [R3]
            flags_reg[rx_status_pkg::BIT_OVERFLOW] <= rx_status_pkg::sticky_next(
                fifo_overflow, flags_read,
                flags_reg[rx_status_pkg::BIT_OVERFLOW]); // [R5]
            flags_reg[rx_status_pkg::BIT_CAMERA_ERR]  <= camera_rx_error; // [R6]
            flags_reg[rx_status_pkg::BIT_SETTLED]     <= rate_measure_settled; // [R7]
            flags_reg[rx_status_pkg::BIT_CLK_MISSING] <= link_clock_missing; // [R7]
            flags_reg[rx_status_pkg::BIT_LINE_TOTAL] <= rx_status_pkg::sticky_next(
                frame_line_total_changed, flags_read,
                flags_reg[rx_status_pkg::BIT_LINE_TOTAL]); // [R8]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // rate bytes follow the measurement; one cycle of latency
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rate_int_reg  <= rx_status_pkg::RST_BYTE;
            rate_frac_reg <= rx_status_pkg::RST_BYTE;
        end else begin
            rate_int_reg  <= rate_integer_byte; // [R9]
            rate_frac_reg <= rate_fraction_byte; // [R10]
        end
    end

endmodule : port_link_flags

// [logic/rx_port_link_sensor_status.sv]
// per-port link and remote sensor status bank behind the host register port
//
// Overview of operation
// [R1] Bit 7 of the link flags is set when a frame had lines of unequal length, held until read.
// [R2] Bit 6 is set on a change of line length and cleared by reading the link flags.
// [R3] Bit 5 is set on a link line-coding error and cleared by reading the link flags.
// [R4] Coding errors count only while the fault counter is enabled with a limit above 1.
// [R5] Bit 4 is set on a packet buffer overflow and cleared by reading the link flags.
// [R6] Read-only bit 3 mirrors the camera receive error summary.
// [R7] Read-only bit 2 shows a settled rate measure and bit 1 a missing link clock.
// [R8] Bit 0 is set on a change of lines per frame and cleared by reading the link flags.
// [R9] The integer megahertz part of the link rate reads from its own byte register.
// [R10] The rate fraction in 1/256 MHz steps reads from its own byte register.
// [R11] Every status register is per port, reached through the port select register.
// [R12] Sensor status registers load from the forward channel with no software write.
// [R13] Alarm register bits 5..0 hold the remote alarms, bits 7:6 read zero.
// [R14] Voltage register holds supply one level in 6:4 and supply zero in 2:0.
// [R15] Temperature register holds the remote level in 2:0, bits 7:3 zero.
// [R16] Reserved bits read zero and writes to status registers do nothing.
module rx_port_link_sensor_status (
    input  wire logic                                                    core_clk,
    input  wire logic                                                    rst_n,
    // host register port, from the serial control interface
    input  wire logic [7:0]                                              reg_addr,
    input  wire logic                                                    reg_wr,
    input  wire logic [7:0]                                              reg_wdata,
    input  wire logic                                                    reg_rd,
    output logic      [7:0]                                              reg_rdata,
    output logic                                                         reg_rvalid,
    // receive front end, one bit or byte per port
    input  wire logic [rx_status_pkg::NUM_PORTS-1:0]                     line_width_inconsistent,
    input  wire logic [rx_status_pkg::NUM_PORTS-1:0]                     line_width_changed,
    input  wire logic [rx_status_pkg::NUM_PORTS-1:0]                     link_coding_fault,
    input  wire logic [rx_status_pkg::NUM_PORTS-1:0]                     fifo_overflow,
    input  wire logic [rx_status_pkg::NUM_PORTS-1:0]                     camera_rx_error,
    input  wire logic [rx_status_pkg::NUM_PORTS-1:0]                     rate_measure_settled,
    input  wire logic [rx_status_pkg::NUM_PORTS-1:0]                     link_clock_missing,
    input  wire logic [rx_status_pkg::NUM_PORTS-1:0]                     frame_line_total_changed,
    input  wire logic [rx_status_pkg::NUM_PORTS-1:0]                     fault_count_en,
    input  wire logic [rx_status_pkg::NUM_PORTS-1:0][rx_status_pkg::LIMIT_W-1:0]
                                                                         link_fault_limit,
    input  wire logic [rx_status_pkg::NUM_PORTS-1:0][7:0]                rate_integer_byte,
    input  wire logic [rx_status_pkg::NUM_PORTS-1:0][7:0]                rate_fraction_byte,
    // forward channel sensor words from each remote serializer
    input  wire logic [rx_status_pkg::NUM_PORTS-1:0]                     fwd_sensor_valid,
    input  wire logic [rx_status_pkg::NUM_PORTS-1:0][rx_status_pkg::ALARM_W-1:0]
                                                                         fwd_alarms,
    input  wire logic [rx_status_pkg::NUM_PORTS-1:0][rx_status_pkg::LEVEL_W-1:0]
                                                                         fwd_supply_one,
    input  wire logic [rx_status_pkg::NUM_PORTS-1:0][rx_status_pkg::LEVEL_W-1:0]
                                                                         fwd_supply_zero,
    input  wire logic [rx_status_pkg::NUM_PORTS-1:0][rx_status_pkg::LEVEL_W-1:0]
                                                                         fwd_temp,
    // selected read port, for the surrounding register file
    output logic      [rx_status_pkg::PORT_W-1:0]                        read_port
);

    localparam int NP = rx_status_pkg::NUM_PORTS;
    localparam int LW = rx_status_pkg::LEVEL_W;
    localparam int AW = rx_status_pkg::ALARM_W;

    ////////////////////////////////////////////////////////////////////////
    // declarations

    logic [7:0]              port_select_reg;
    logic [7:0]              port_select_next;
    logic [rx_status_pkg::PORT_W-1:0] sel_port;
    logic [NP-1:0]           flags_read;
    logic [NP-1:0][7:0]      flags_reg;
    logic [NP-1:0][7:0]      rate_int_reg;
    logic [NP-1:0][7:0]      rate_frac_reg;
    logic [NP-1:0][AW-1:0]   alarm_reg;
    logic [NP-1:0][LW-1:0]   supply_one_reg;
    logic [NP-1:0][LW-1:0]   supply_zero_reg;
    logic [NP-1:0][LW-1:0]   temp_reg;
    logic [7:0]              rdata_next;
    logic                    sel_wr;

    ////////////////////////////////////////////////////////////////////////
    // port select register

    assign sel_wr  = reg_wr && (reg_addr == rx_status_pkg::ADDR_PORT_SELECT);
    assign sel_port = port_select_reg[rx_status_pkg::PSEL_READ_LSB +: rx_status_pkg::PORT_W];

    always_comb begin
        port_select_next = port_select_reg;
        if (sel_wr) begin
            port_select_next = reg_wdata; // [R11]
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            port_select_reg <= rx_status_pkg::RST_PORT_SELECT;
        end else begin
            port_select_reg <= port_select_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            read_port <= '0;
        end else begin
            read_port <= port_select_next[rx_status_pkg::PSEL_READ_LSB +:
                                          rx_status_pkg::PORT_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read-to-clear goes only to the copy the host is looking at

    always_comb begin
        flags_read = '0;
        if (reg_rd && (reg_addr == rx_status_pkg::ADDR_LINK_FLAGS)) begin
            flags_read[sel_port] = 1'b1; // [R11]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // per-port link flag banks

    for (genvar p = 0; p < NP; p++) begin : g_port
        port_link_flags u_flags (
            .core_clk                 (core_clk),
            .rst_n                    (rst_n),
            .line_width_inconsistent  (line_width_inconsistent[p]),
            .line_width_changed       (line_width_changed[p]),
            .link_coding_fault        (link_coding_fault[p]),
            .fifo_overflow            (fifo_overflow[p]),
            .camera_rx_error          (camera_rx_error[p]),
            .rate_measure_settled     (rate_measure_settled[p]),
            .link_clock_missing       (link_clock_missing[p]),
            .frame_line_total_changed (frame_line_total_changed[p]),
            .fault_count_en           (fault_count_en[p]),
            .link_fault_limit         (link_fault_limit[p]),
            .rate_integer_byte        (rate_integer_byte[p]),
            .rate_fraction_byte       (rate_fraction_byte[p]),
            .flags_read               (flags_read[p]),
            .flags_reg                (flags_reg[p]),
            .rate_int_reg             (rate_int_reg[p]),
            .rate_frac_reg            (rate_frac_reg[p])
        );

        // sensor mirror: the serializer owns these, software cannot write
        always_ff @(posedge core_clk) begin
            if (!rst_n) begin
                alarm_reg[p]       <= '0;
                supply_one_reg[p]  <= '0;
                supply_zero_reg[p] <= '0;
                temp_reg[p]        <= '0;
            end else if (fwd_sensor_valid[p]) begin
                alarm_reg[p]       <= fwd_alarms[p]; // [R12] [R13]
                supply_one_reg[p]  <= fwd_supply_one[p]; // [R12] [R14]
                supply_zero_reg[p] <= fwd_supply_zero[p]; // [R12] [R14]
                temp_reg[p]        <= fwd_temp[p]; // [R12] [R15]
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read mux; unmapped offsets and reserved bits read zero

    always_comb begin
        rdata_next = rx_status_pkg::RST_BYTE; // [R16]
        unique case (reg_addr)
            rx_status_pkg::ADDR_PORT_SELECT: begin
                rdata_next = port_select_reg;
            end
            rx_status_pkg::ADDR_LINK_FLAGS: begin
                rdata_next = flags_reg[sel_port]; // [R11]
            end
            rx_status_pkg::ADDR_RATE_INT: begin
                rdata_next = rate_int_reg[sel_port]; // [R9]
            end
            rx_status_pkg::ADDR_RATE_FRAC: begin
                rdata_next = rate_frac_reg[sel_port]; // [R10]
            end
            rx_status_pkg::ADDR_ALARM: begin
                rdata_next[AW-1:0] = alarm_reg[sel_port]; // [R13]
            end
            rx_status_pkg::ADDR_VOLTAGE: begin
                rdata_next[rx_status_pkg::SUPPLY1_LSB +: LW] = supply_one_reg[sel_port]; // [R14]
                rdata_next[rx_status_pkg::SUPPLY0_LSB +: LW] = supply_zero_reg[sel_port]; // [R14]
            end
            rx_status_pkg::ADDR_TEMP: begin
                rdata_next[rx_status_pkg::TEMP_LSB +: LW] = temp_reg[sel_port]; // [R15]
            end
            default: begin
                rdata_next = rx_status_pkg::RST_BYTE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // read data is captured with the flag values from before the clear

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rdata <= rx_status_pkg::RST_BYTE;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_rd;
        end
    end

endmodule : rx_port_link_sensor_status

// [verif/remote_serializer_model.sv]
// behavioural remote serializer feeding the forward sensor channel
module remote_serializer_model (
    input  wire logic            core_clk,
    input  wire logic            load_req,
    input  wire logic [1:0]      load_port,
    input  wire logic [5:0]      load_alarms,
    input  wire logic [2:0]      load_s1,
    input  wire logic [2:0]      load_s0,
    input  wire logic [2:0]      load_temp,
    output logic      [3:0]      fwd_sensor_valid,
    output logic      [3:0][5:0] fwd_alarms,
    output logic      [3:0][2:0] fwd_supply_one,
    output logic      [3:0][2:0] fwd_supply_zero,
    output logic      [3:0][2:0] fwd_temp
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {fwd_sensor_valid, fwd_alarms, fwd_supply_one, fwd_supply_zero, fwd_temp} = '0;
    end
    // fields not qualified by valid flip every cycle, so a stale capture shows up
    always @(posedge core_clk) begin
        fwd_sensor_valid <= '0;
        fwd_alarms       <= ~fwd_alarms;
        fwd_supply_one   <= ~fwd_supply_one;
        fwd_supply_zero  <= ~fwd_supply_zero;
        fwd_temp         <= ~fwd_temp;
        if (load_req) begin
            fwd_sensor_valid[load_port] <= 1'b1;
            fwd_alarms[load_port]       <= load_alarms;
            fwd_supply_one[load_port]   <= load_s1;
            fwd_supply_zero[load_port]  <= load_s0;
            fwd_temp[load_port]         <= load_temp;
        end
    end
endmodule : remote_serializer_model

// [verif/rx_status_monitor.sv]
// concurrent checks on the status bank register port
module rx_status_monitor (
    input wire logic            core_clk,
    input wire logic            rst_n,
    input wire logic [7:0]      reg_addr,
    input wire logic            reg_wr,
    input wire logic [7:0]      reg_wdata,
    input wire logic            reg_rd,
    input wire logic [7:0]      reg_rdata,
    input wire logic            reg_rvalid,
    input wire logic [3:0]      link_clock_missing,
    input wire logic [3:0][7:0] rate_integer_byte,
    input wire logic [1:0]      read_port
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    ////////////////////////////////////////////////////////////////////////////
    // inputs lag one cycle in the mirrors, so expectations lag twice
    logic [3:0][7:0] rate_prev;
    logic [3:0]      miss_prev;
    logic [7:0]      rate_exp;
    logic            miss_exp;
    always_ff @(posedge core_clk) begin
        rate_prev <= rate_integer_byte;
        miss_prev <= link_clock_missing;
        rate_exp  <= rate_prev[read_port];
        miss_exp  <= miss_prev[read_port];
    end
    ////////////////////////////////////////////////////////////////////////////
    read_answer_a: assert property (reg_rd |=> reg_rvalid)
        else $error("no answer to read");
    answer_quiet_a: assert property (!reg_rd |=> !reg_rvalid)
        else $error("answer without read");
    rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("rdata moved");
    unmapped_zero_a: assert property (reg_rd && reg_addr == 8'h00 |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    port_route_a: assert property (reg_wr && reg_addr == rx_status_pkg::ADDR_PORT_SELECT
        |=> read_port == $past(reg_wdata[5:4])) else $error("port select not applied");
    port_hold_a: assert property (!(reg_wr && reg_addr == rx_status_pkg::ADDR_PORT_SELECT)
        |=> $stable(read_port)) else $error("port select moved");
    alarm_spare_a: assert property (reg_rd && reg_addr == rx_status_pkg::ADDR_ALARM
        |=> reg_rdata[7:6] == 2'h0) else $error("alarm spare bits set");
    volt_spare_a: assert property (reg_rd && reg_addr == rx_status_pkg::ADDR_VOLTAGE
        |=> !reg_rdata[7] && !reg_rdata[3]) else $error("voltage spare bits set");
    temp_spare_a: assert property (reg_rd && reg_addr == rx_status_pkg::ADDR_TEMP
        |=> reg_rdata[7:3] == 5'h00) else $error("temperature spare bits set");
    rate_mirror_a: assert property (reg_rd && reg_addr == rx_status_pkg::ADDR_RATE_INT
        |=> reg_rdata == rate_exp) else $error("rate integer byte wrong");
    clock_missing_a: assert property (reg_rd && reg_addr == rx_status_pkg::ADDR_LINK_FLAGS
        |=> reg_rdata[1] == miss_exp) else $error("clock missing bit wrong");
endmodule : rx_status_monitor

bind rx_port_link_sensor_status rx_status_monitor u_mon (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .link_clock_missing(link_clock_missing), .rate_integer_byte(rate_integer_byte),
    .read_port(read_port));

// [verif/rx_port_link_sensor_status_bench.sv]
// self-checking bench for the receive-port status bank
module rx_port_link_sensor_status_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic            core_clk, rst_n, reg_wr, reg_rd, reg_rvalid, ld_req;
    logic [7:0]      reg_addr, reg_wdata, reg_rdata;
    logic [4:0][3:0] ev;
    logic [3:0]      cam, settled, missing, fc_en, fwd_valid;
    logic [3:0][7:0] limit, rate_i, rate_f, e51, e52, e53;
    logic [3:0][5:0] fwd_al;
    logic [3:0][2:0] fwd_s1, fwd_s0, fwd_t;
    logic [1:0]      read_port, ld_port;
    logic [5:0]      ld_al;
    logic [2:0]      ld_s1, ld_s0, ld_t;
    logic [7:0]      exp_q[$];
    logic [7:0]      adr_q[$];
    int              num_errors, compares, p;
    rx_port_link_sensor_status u_dut (
        .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .line_width_inconsistent(ev[0]), .line_width_changed(ev[1]), .link_coding_fault(ev[2]),
        .fifo_overflow(ev[3]), .frame_line_total_changed(ev[4]), .camera_rx_error(cam),
        .rate_measure_settled(settled), .link_clock_missing(missing), .fault_count_en(fc_en),
        .link_fault_limit(limit), .rate_integer_byte(rate_i), .rate_fraction_byte(rate_f),
        .fwd_sensor_valid(fwd_valid), .fwd_alarms(fwd_al), .fwd_supply_one(fwd_s1),
        .fwd_supply_zero(fwd_s0), .fwd_temp(fwd_t), .read_port(read_port));
    remote_serializer_model u_far (
        .core_clk(core_clk), .load_req(ld_req), .load_port(ld_port), .load_alarms(ld_al),
        .load_s1(ld_s1), .load_s0(ld_s0), .load_temp(ld_t), .fwd_sensor_valid(fwd_valid),
        .fwd_alarms(fwd_al), .fwd_supply_one(fwd_s1), .fwd_supply_zero(fwd_s0),
        .fwd_temp(fwd_t));
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : tally_and_finish
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge core_clk);
        reg_rd = 1'b1;
        reg_addr = a;
        exp_q.push_back(e);
        adr_q.push_back(a);
        @(negedge core_clk);
        reg_rd = 1'b0;
    endtask : rd
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr
    task automatic pulse(input logic [4:0][3:0] v);
        @(negedge core_clk);
        ev = v;
        @(negedge core_clk);
        ev = '0;
    endtask : pulse
    function automatic logic [7:0] flags(input logic [3:0] sticky, input logic s);
        flags = {sticky, cam[p], settled[p], missing[p], s};
    endfunction : flags
    ////////////////////////////////////////////////////////////////////////////
    // results are compared in arrival order against the driver's notes
    always @(negedge core_clk) begin
        if (reg_rvalid === 1'b1) begin
            compares++;
            if (exp_q.size() == 0) begin
                num_errors++;
                $display("mismatch answer expected none seen %h", reg_rdata);
            end else if (reg_rdata !== exp_q[0]) begin
                num_errors++;
                $display("mismatch reg %h expected %h seen %h", adr_q[0], exp_q[0], reg_rdata);
            end
            if (exp_q.size() != 0) begin
                void'(exp_q.pop_front());
                void'(adr_q.pop_front());
            end
        end
    end
    initial begin
        #100us;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        {reg_wr, reg_rd, reg_addr, reg_wdata, ev, cam, settled, missing, fc_en} = '0;
        {limit, rate_i, rate_f, ld_req, ld_port, ld_al, ld_s1, ld_s0, ld_t} = '0;
        rst_n = 1'b0;
        void'($urandom(90779));
        repeat (20) @(negedge core_clk);
        rst_n = 1'b1;
        @(negedge core_clk);
        rd(8'h4C, 8'h01);
        rd(8'h00, 8'h00);
        for (int a = 8'h4E; a <= 8'h53; a++) rd(a[7:0], 8'h00);
        {cam, settled, missing} = 12'($urandom);
        fc_en = 4'hF;
        for (p = 0; p < 4; p++) begin
            rate_i[p] = 8'($urandom);
            rate_f[p] = 8'($urandom);
            limit[p] = 8'(2 + $urandom_range(253));
            {ld_al, ld_s1, ld_s0, ld_t} = 15'($urandom);
            ld_port = 2'(p);
            e51[p] = {2'h0, ld_al};
            e52[p] = {1'b0, ld_s1, 1'b0, ld_s0};
            e53[p] = {5'h00, ld_t};
            @(negedge core_clk);
            ld_req = 1'b1;
            @(negedge core_clk);
            ld_req = 1'b0;
        end
        pulse({5{4'hF}});
        for (p = 0; p < 4; p++) begin
            wr(8'h4C, 8'(p << 4));
            wr(8'h4E, 8'hFF);
            wr(8'h4F, 8'hFF);
            rd(8'h4E, flags(4'hF, 1'b1));
            rd(8'h4E, flags(4'h0, 1'b0));
            rd(8'h4F, rate_i[p]);
            rd(8'h50, rate_f[p]);
            rd(8'h51, e51[p]);
            rd(8'h52, e52[p]);
            rd(8'h53, e53[p]);
        end
        p = 3;
        fc_en = 4'h7;
        // coding fault on port 3 only, counter disabled first
        pulse(20'h00800);
        fc_en = 4'hF;
        limit[3] = 8'h01;
        pulse(20'h00800);
        rd(8'h4E, flags(4'h0, 1'b0));
        limit[3] = 8'h02;
        pulse(20'h00800);
        rd(8'h4E, flags(4'h2, 1'b0));
        @(negedge core_clk);
        ev[3] = 4'h8;
        reg_rd = 1'b1;
        reg_addr = 8'h4E;
        exp_q.push_back(flags(4'h0, 1'b0));
        adr_q.push_back(8'h4E);
        @(negedge core_clk);
        reg_rd = 1'b0;
        ev = '0;
        rd(8'h4E, flags(4'h1, 1'b0));
        repeat (4) @(negedge core_clk);
        if (exp_q.size() != 0) begin
            num_errors++;
            $display("mismatch pending answers expected 0 seen %0d", exp_q.size());
        end
        tally_and_finish();
    end
endmodule : rx_port_link_sensor_status_bench
